// ===== logic/scb_sysctl.sv
// Purpose: peripheral reset and clock-gate bank, lockup reset, fuse boot loader
// Assumes: AHB-Lite single word transfers, zero wait states
// Notes:   loader fills the code store one byte per write strobe
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [RULE1] reset bank layout, all bits reset high
// [RULE2] reset bit low holds peripheral reset
// [RULE3] clock gate high lets clock through
// [RULE4] clock gate layout, all bits reset low
// [RULE5] refresh variant pulses gated clocks
// [RULE6] pins need own and pin-unit gates
// [RULE7] hang enable resets system on lockup
// [RULE8] fuse boot word read-only, captured
// [RULE9] boot fields used only when enabled
// [RULE10] serial clock divide 2,6,12,52
// [RULE11] load extent, remainder filled zero
// [RULE12] double read each block until agree
// [RULE13] release wait in oscillator cycles
// [RULE14] read opcode starts every fetch
// [RULE15] latency bits before data
// [RULE16] address width 16, 24, 32 bits
// [RULE17] late sample on falling edge
// [RULE18] nonzero busy status restarts fetch
// [RULE19] read-timing fuse bits kept zero
// [RULE20] fuse tag read-only, captured
// [RULE21] cpu identity fixed read-only
// [RULE22] unit identity fixed read-only
// [RULE23] opcode, address, latency, data, MSB first
module scb_sysctl
    import scb_pkg::*;
#(
    parameter bit          HAS_REFRESH = 1'b1,
    parameter logic [31:0] CPU_ID      = 32'h0000_1234, // arbitrary value
    parameter logic [31:0] UNIT_ID     = 32'h0000_5678, // arbitrary value
    parameter logic [19:0] WAIT_OSC [8] = WAIT_OSC_DEF
)(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // register bus
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // fuse array and processor
    input  wire logic [31:0] fuse_boot_word,
    input  wire logic [31:0] fuse_tag,
    input  wire logic        cpu_lockup,
    output logic             lockup_reset,
    // peripheral controls
    output logic [24:0]      blk_rst_n,
    output logic [24:0]      blk_clk_en,
    output logic [24:0]      pin_access_en,
    // serial boot memory
    output logic             rom_cs_n,
    output logic             rom_sck,
    output logic             rom_so,
    input  wire logic        rom_si,
    // code store load port
    output logic             load_wr,
    output logic [16:0]      load_addr,
    output logic [7:0]       load_data,
    output logic             core_hold
);
    typedef struct packed {
        scb_state_t        st;
        logic              wr_pend;
        logic [11:0]       waddr;
        logic [31:0]       rdata;
        logic [31:0]       rst;
        logic [31:0]       gate;
        logic              hang;
        logic [31:0]       fuse;
        logic [31:0]       tag;
        logic              lockrst;
        logic [24:0]       clken;
        logic [24:0]       pin;
        logic              cs_n;
        logic              sck;
        logic              so;
        logic [39:0]       sh;
        logic [10:0]       bcnt;
        logic [7:0]        rx;
        logic              pass;
        logic              mism;
        logic              restart;
        logic [9:0]        blk;
        logic [16:0]       fill;
        logic [19:0]       wcnt;
        logic              wr;
        logic [16:0]       wa;
        logic [7:0]        wd;
        logic              hold;
        logic [127:0][7:0] buff;
    } scb_state_s_t;

    scb_state_s_t r;
    scb_state_s_t n;

    scb_div_if osc_if ();
    scb_div_if sck_if ();
    scb_div_if ref_if ();

    // ****************
    // boot word decode
    // ****************
    logic [31:0] eff;
    logic [2:0]  size_code;
    logic [10:0] nblk;
    logic [6:0]  nsend;
    logic [31:0] afield;

    // [RULE9] defaults unless enabled
    assign eff       = r.fuse[EN_BIT] ? r.fuse : FUSE_DEFAULT;
    assign size_code = (eff[SIZE_LSB +: 3] > SIZE_MAX_CODE) ? SIZE_MAX_CODE : eff[SIZE_LSB +: 3];
    // [RULE11] blocks in extent
    assign nblk      = NBLK_FULL >> size_code;

    // [RULE16] address width select
    always_comb begin
        unique case (eff[AW_LSB +: 2])
            2'h0:    afield = {r.blk[8:0], 7'h00, 16'h0000};
            2'h2:    afield = {15'h0000, r.blk, 7'h00};
            default: afield = {7'h00, r.blk, 7'h00, 8'h00};
        endcase
    end

    // [RULE15] latency bits follow the address
    assign nsend = 7'h08 + ((eff[AW_LSB +: 2] == 2'h0) ? 7'h10 :
                   (eff[AW_LSB +: 2] == 2'h2) ? 7'h20 : 7'h18) + {2'h0, eff[LAT_LSB +: 5]};

    assign osc_if.en  = (r.st == ST_WAIT);
    assign osc_if.per = OSC_TICK_CYC;
    assign sck_if.en  = (r.st == ST_SEND) || (r.st == ST_STAT) || (r.st == ST_DATA) || (r.st == ST_GAP);
    // [RULE10] half period of the serial clock
    assign sck_if.per = SCK_DIV[eff[SPD_LSB +: 2]] >> 1;
    assign ref_if.en  = HAS_REFRESH;
    assign ref_if.per = REFRESH_PER;

    scb_tick_div u_osc (.sys_clk(sys_clk), .sys_rst(sys_rst), .d(osc_if.gen));
    scb_tick_div u_sck (.sys_clk(sys_clk), .sys_rst(sys_rst), .d(sck_if.gen));
    scb_tick_div u_ref (.sys_clk(sys_clk), .sys_rst(sys_rst), .d(ref_if.gen));

    // ****************
    // next state
    // ****************
    logic cap;
    logic done_byte;
    logic [7:0] rxb;
    logic final_pass;
    logic chk;

    always_comb begin
        n          = r;
        chk        = !eff[NOCHK_BIT];
        final_pass = !chk || r.pass;
        cap        = sck_if.tick && (eff[LATE_BIT] ? r.sck : !r.sck);
        rxb        = {r.rx[6:0], rom_si};
        done_byte  = cap && (r.bcnt[2:0] == 3'h7);
        n.wr       = 1'b0;

        // [RULE7] lockup reset gated by enable
        n.lockrst = cpu_lockup && r.hang;
        // [RULE3] gate or refresh pulse
        // [RULE5] refresh reaches gated peripherals
        n.clken   = r.gate[24:0] | {NPERIPH{HAS_REFRESH && ref_if.tick}};
        // [RULE6] pin unit gate also needed
        n.pin     = r.gate[24:0] & {NPERIPH{r.gate[PIN_UNIT_BIT]}};

        // data phase of a write; unmapped and read-only words ignore it
        n.wr_pend = hsel && hready && htrans[1] && hwrite;
        if (hsel && hready) begin
            n.waddr = haddr[11:0];
        end
        if (r.wr_pend) begin
            unique case (r.waddr)
                // [RULE2] reserved bits stay high
                OFF_RST:  n.rst  = (hwdata & RST_MASK) | ~RST_MASK;
                OFF_GATE: n.gate = hwdata & GATE_MASK;
                OFF_HANG: n.hang = hwdata[0];
                default:  n.hang = r.hang;
            endcase
        end
        // read sees a write landing in the same cycle
        if (hsel && hready && htrans[1] && !hwrite) begin
            unique case (haddr[11:0])
                OFF_RST:  n.rdata = n.rst;
                OFF_GATE: n.rdata = n.gate;
                OFF_HANG: n.rdata = {31'h0, n.hang};
                OFF_FUSE: n.rdata = r.fuse;
                OFF_TAG:  n.rdata = r.tag;
                OFF_CPU:  n.rdata = CPU_ID;
                OFF_UNIT: n.rdata = UNIT_ID;
                default:  n.rdata = 32'h0000_0000;
            endcase
        end

        unique case (r.st)
            ST_FUSE: begin
                // [RULE8] boot word captured once
                // [RULE20] tag captured once
                n.fuse = fuse_boot_word;
                n.tag  = fuse_tag;
                n.wcnt = 20'h00000;
                n.st   = ST_WAIT;
            end
            ST_WAIT: begin
                // [RULE13] count oscillator periods
                if (osc_if.tick) begin
                    if (r.wcnt + 20'h00001 >= WAIT_OSC[eff[WAIT_LSB +: 3]]) begin
                        n.sh = {eff[OP_LSB +: 8], afield};
                        n.st = ST_SEND;
                    end else begin
                        n.wcnt = r.wcnt + 20'h00001;
                    end
                end
            end
            ST_SEND: begin
                if (sck_if.tick) begin
                    if (r.cs_n) begin
                        // [RULE14] opcode bit first
                        n.cs_n = 1'b0;
                        n.so   = r.sh[39];
                        n.bcnt = 11'h000;
                    end else if (!r.sck) begin
                        n.sck = 1'b1;
                    end else begin
                        // [RULE23] shift out MSB first
                        n.sck  = 1'b0;
                        n.sh   = {r.sh[38:0], 1'b0};
                        n.so   = r.sh[38];
                        n.bcnt = r.bcnt + 11'h001;
                        if (r.bcnt == {4'h0, nsend} - 11'h001) begin
                            n.so   = 1'b0;
                            n.bcnt = 11'h000;
                            n.st   = eff[BUSY_BIT] ? ST_STAT : ST_DATA;
                        end
                    end
                end
            end
            ST_STAT, ST_DATA: begin
                if (sck_if.tick) begin
                    n.sck = !r.sck;
                end
                // [RULE17] capture edge select
                if (cap) begin
                    n.rx   = rxb;
                    n.bcnt = r.bcnt + 11'h001;
                end
                if (done_byte && r.st == ST_STAT) begin
                    // [RULE18] busy status restarts
                    n.restart = (rxb != 8'h00);
                    n.bcnt    = 11'h000;
                    n.st      = (rxb != 8'h00) ? ST_GAP : ST_DATA;
                end else if (done_byte) begin
                    // [RULE12] first read stored, second compared
                    if (chk && !r.pass) begin
                        n.buff[r.bcnt[9:3]] = rxb;
                    end
                    if (chk && r.pass && r.buff[r.bcnt[9:3]] != rxb) begin
                        n.mism = 1'b1;
                    end
                    if (final_pass) begin
                        n.wr = 1'b1;
                        n.wa = {r.blk, r.bcnt[9:3]};
                        n.wd = rxb;
                    end
                    if (r.bcnt[9:0] == BLK_LAST_BIT) begin
                        n.st = ST_GAP;
                    end
                end
            end
            ST_GAP: begin
                if (sck_if.tick) begin
                    if (r.sck) begin
                        n.sck = 1'b0;
                    end else begin
                        n.cs_n = 1'b1;
                        n.st   = ST_SEND;
                        if (r.restart) begin
                            n.restart = 1'b0;
                        end else if (chk && !r.pass) begin
                            n.pass = 1'b1;
                            n.mism = 1'b0;
                        end else if (chk && r.mism) begin
                            // [RULE12] repeat the pair
                            n.pass = 1'b0;
                            n.mism = 1'b0;
                        end else begin
                            n.pass = 1'b0;
                            if ({1'b0, r.blk} == nblk - 11'h001) begin
                                // [RULE11] zero the unloaded part
                                n.fill = {nblk[9:0], 7'h00};
                                n.st   = (nblk == NBLK_FULL) ? ST_DONE : ST_FILL;
                            end else begin
                                n.blk = r.blk + 10'h001;
                            end
                        end
                    end
                end
            end
            ST_FILL: begin
                n.wr   = 1'b1;
                n.wa   = r.fill;
                n.wd   = 8'h00;
                n.fill = r.fill + 17'h00001;
                if (r.fill == FILL_LAST) begin
                    n.st = ST_DONE;
                end
            end
            ST_DONE: begin
                n.hold = 1'b0;
            end
            default: begin
                n.st = ST_FUSE;
            end
        endcase

        // the address must follow a block step before the next frame
        if (r.st == ST_GAP && n.st == ST_SEND) begin
            n.sh = {eff[OP_LSB +: 8], (n.blk != r.blk) ?
                    ((eff[AW_LSB +: 2] == 2'h0) ? {n.blk[8:0], 23'h0} :
                     (eff[AW_LSB +: 2] == 2'h2) ? {15'h0, n.blk, 7'h0} :
                     {7'h0, n.blk, 15'h0}) : afield};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            r       <= '0;
            r.st    <= ST_FUSE;
            // [RULE1] all reset bits high
            r.rst   <= RST_RESET;
            // [RULE4] all gates low
            r.gate  <= GATE_RESET;
            r.hang  <= HANG_RESET;
            r.cs_n  <= 1'b1;
            r.hold  <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign hreadyout     = 1'b1;
    assign hresp         = 1'b0;
    assign hrdata        = r.rdata;
    assign lockup_reset  = r.lockrst;
    assign blk_rst_n     = r.rst[24:0];
    assign blk_clk_en    = r.clken;
    assign pin_access_en = r.pin;
    assign rom_cs_n      = r.cs_n;
    assign rom_sck       = r.sck;
    assign rom_so        = r.so;
    assign load_wr       = r.wr;
    assign load_addr     = r.wa;
    assign load_data     = r.wd;
    assign core_hold     = r.hold;

    // ****************
    // checks
    // ****************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_rst_wr;
        hsel && hready && htrans[1] && hwrite && haddr[11:0] == OFF_RST ##1 1'b1;
    endsequence
    sequence s_cpu_rd;
        hsel && hready && htrans[1] && !hwrite && haddr[11:0] == OFF_CPU;
    endsequence
    sequence s_unit_rd;
        hsel && hready && htrans[1] && !hwrite && haddr[11:0] == OFF_UNIT;
    endsequence

    property p_rst_init;
        $fell(sys_rst) |-> blk_rst_n == 25'h1ffffff;
    endproperty
    a_rst_init: assert property (p_rst_init) else $error("reset bank not high after reset"); // [RULE1]
    property p_rst_wr;
        s_rst_wr |=> blk_rst_n == 25'($past(hwdata) | ~RST_MASK);
    endproperty
    a_rst_wr: assert property (p_rst_wr) else $error("reset bank write lost"); // [RULE2]
    property p_gate_init;
        $fell(sys_rst) |-> blk_clk_en == 25'h0000000;
    endproperty
    a_gate_init: assert property (p_gate_init) else $error("clock gates not low after reset"); // [RULE4]
    property p_pin;
        !r.gate[PIN_UNIT_BIT] |=> pin_access_en == 25'h0000000;
    endproperty
    a_pin: assert property (p_pin) else $error("pin access without pin unit gate"); // [RULE6]
    property p_lock;
        cpu_lockup && !r.hang |=> !lockup_reset;
    endproperty
    a_lock: assert property (p_lock) else $error("lockup reset while disabled"); // [RULE7]
    property p_fuse_ro;
        r.st != ST_FUSE |=> $stable(r.fuse) && $stable(r.tag);
    endproperty
    a_fuse_ro: assert property (p_fuse_ro) else $error("fuse value changed after boot"); // [RULE8]
    property p_sck_fast;
        $rose(rom_sck) && eff[SPD_LSB +: 2] == 2'h0 |=> $fell(rom_sck);
    endproperty
    a_sck_fast: assert property (p_sck_fast) else $error("divide by two clock too slow"); // [RULE10]
    property p_hold;
        r.st != ST_DONE |-> core_hold;
    endproperty
    a_hold: assert property (p_hold) else $error("core released before load done"); // [RULE13]
    property p_opcode;
        $fell(rom_cs_n) |-> rom_so == eff[OP_LSB + 7] && !rom_sck;
    endproperty
    a_opcode: assert property (p_opcode) else $error("frame does not open with opcode"); // [RULE14]
    property p_cpu_id;
        s_cpu_rd |=> hrdata == CPU_ID;
    endproperty
    a_cpu_id: assert property (p_cpu_id) else $error("cpu identity wrong"); // [RULE21]
    property p_unit_id;
        s_unit_rd |=> hrdata == UNIT_ID;
    endproperty
    a_unit_id: assert property (p_unit_id) else $error("unit identity wrong"); // [RULE22]
    property p_idle_sck;
        rom_cs_n |-> !rom_sck;
    endproperty
    a_idle_sck: assert property (p_idle_sck) else $error("serial clock moves while deselected"); // [RULE23]

endmodule : scb_sysctl
`default_nettype wire

// ===== logic/scb_pkg.sv
// Purpose: shared constants and types of the system control and boot block
// Assumes: 50 MHz system clock, word-aligned register bus
// Notes:   fuse field positions follow the boot word layout
package scb_pkg;

    // ****************
    // timing
    // ****************
    localparam int          SYS_PERIOD_NS = 20;
    localparam int          OSC_PERIOD_NS = 1000;
    localparam logic [15:0] OSC_TICK_CYC  = 16'(OSC_PERIOD_NS / SYS_PERIOD_NS);

    // ****************
    // register map
    // ****************
    localparam logic [11:0] OFF_RST  = 12'h000;
    localparam logic [11:0] OFF_GATE = 12'h004;
    localparam logic [11:0] OFF_HANG = 12'h008;
    localparam logic [11:0] OFF_FUSE = 12'h00c;
    localparam logic [11:0] OFF_TAG  = 12'h010;
    localparam logic [11:0] OFF_CPU  = 12'h014;
    localparam logic [11:0] OFF_UNIT = 12'h018;

    localparam int          NPERIPH      = 25;
    localparam int          PIN_UNIT_BIT = 22;
    localparam logic [31:0] RST_MASK     = 32'h01f3_0373;
    localparam logic [31:0] RST_RESET    = 32'hffff_ffff;
    localparam logic [31:0] GATE_MASK    = 32'h01e3_0373;
    localparam logic [31:0] GATE_RESET   = 32'h0000_0000;
    localparam logic        HANG_RESET   = 1'h1;

    // ****************
    // boot word fields
    // ****************
    localparam int SPD_LSB   = 0;
    localparam int SIZE_LSB  = 2;
    localparam int NOCHK_BIT = 5;
    localparam int WAIT_LSB  = 6;
    localparam int OP_LSB    = 9;
    localparam int LAT_LSB   = 17;
    localparam int AW_LSB    = 22;
    localparam int LATE_BIT  = 24;
    localparam int BUSY_BIT  = 25;
    localparam int EN_BIT    = 31;
    localparam logic [31:0] FUSE_DEFAULT = 32'h0140_0701;

    localparam logic [15:0] SCK_DIV [4] = '{16'h0002, 16'h0006, 16'h000c, 16'h0034};
    localparam logic [19:0] WAIT_OSC_DEF [8] = '{20'h00001, 20'h003e8, 20'h00bb8, 20'h02710,
                                                 20'h07530, 20'h186a0, 20'h493e0, 20'h7a120};
    localparam logic [10:0] NBLK_FULL     = 11'h400;
    localparam logic [2:0]  SIZE_MAX_CODE = 3'h5;
    localparam logic [9:0]  BLK_LAST_BIT  = 10'h3ff;
    localparam logic [16:0] FILL_LAST     = 17'h1ffff;

    localparam logic [15:0] REFRESH_DIVCOUNT = 16'h000f;
    localparam logic [15:0] REFRESH_PER      = 16'((REFRESH_DIVCOUNT + 16'h0001) << 4);

    typedef enum logic [2:0] {
        ST_FUSE = 3'h0,
        ST_WAIT = 3'h1,
        ST_SEND = 3'h3,
        ST_STAT = 3'h2,
        ST_DATA = 3'h6,
        ST_GAP  = 3'h7,
        ST_FILL = 3'h5,
        ST_DONE = 3'h4
    } scb_state_t;

endpackage : scb_pkg

// ===== logic/scb_div_if.sv
// Purpose: carrier between the block and its tick dividers
// Assumes: one clock domain
// Notes:   period of zero behaves as one
`timescale 1ns/1ps
`default_nettype none
interface scb_div_if;
    logic        en;
    logic [15:0] per;
    logic        tick;
    modport ctl (output en, output per, input tick);
    modport gen (input en, input per, output tick);
endinterface : scb_div_if
`default_nettype wire

// ===== logic/scb_tick_div.sv
// Purpose: enable-pulse divider, one pulse every per cycles while en
// Assumes: per stable while en is high
// Notes:   restarts from zero whenever en drops
`timescale 1ns/1ps
`default_nettype none
module scb_tick_div
    import scb_pkg::*;
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    // divider control
    scb_div_if.gen    d
);
    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } scb_div_state_t;

    scb_div_state_t r;
    scb_div_state_t n;

    always_comb begin
        n      = r;
        n.tick = 1'b0;
        if (!d.en) begin
            n.cnt = 16'h0000;
        end else if (r.cnt + 16'h0001 >= d.per) begin
            n.cnt  = 16'h0000;
            n.tick = 1'b1;
        end else begin
            n.cnt = r.cnt + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign d.tick = r.tick;

endmodule : scb_tick_div
`default_nettype wire

// ===== verification/scb_rom_model.sv
// Purpose: serial boot memory seen by the loader
// Assumes: opcode, 24-bit address, no latency bits, no status byte
// Notes:   byte k of every block reads back as k xor 5a
`timescale 1ns/1ps
`default_nettype none
module scb_rom_model (
    // serial link
    input  wire logic   rom_cs_n,
    input  wire logic   rom_sck,
    input  wire logic   rom_so,
    output logic        rom_si,
    // last request seen
    output logic [7:0]  op,
    output logic [31:0] adr
);
    int unsigned n;
    int unsigned d;
    logic [7:0]  b;

    initial begin
        rom_si = 1'b0;
        n = 0;
    end

    always @(negedge rom_cs_n) begin
        n = 0;
        adr = 32'h0000_0000;
    end

    always @(posedge rom_sck) begin
        if (n < 8)
            op = {op[6:0], rom_so};
        else if (n < 32)
            adr = {adr[30:0], rom_so};
        n = n + 1;
    end

    // status off: data follows the address at once
    always @(negedge rom_sck) begin
        if (n >= 32) begin
            d = n - 32;
            b = 8'((d / 8) % 128) ^ 8'h5a;
            rom_si <= b[7 - (d % 8)];
        end
    end

    // released line does not keep its last level
    always @(posedge rom_cs_n) rom_si <= ~rom_si;
endmodule : scb_rom_model
`default_nettype wire

// ===== verification/scb_sysctl_bench.sv
// Purpose: self-checking bench of the system control block
// Assumes: zero-wait register bus, release wait shortened to one tick
// Notes:   only the first four loaded bytes of each boot are checked to keep the run short
`timescale 1ns/1ps
`default_nettype none
module scb_sysctl_bench;
    import scb_pkg::*;
    // ****************
    // signals
    // ****************
    // read-timing bits zero; enable clear, opcode field 0f
    localparam logic [31:0] FUSE_WORD = 32'h0000_1e00;
    // enabled: divide by 2, single read, rising capture, opcode 0f
    localparam logic [31:0] FUSE_FAST = 32'h8040_1e20;
    localparam logic [31:0] TAG_VAL   = 32'h1357_9bdf;
    localparam logic [31:0] CPU_VAL   = 32'h0000_0abc; // arbitrary value
    localparam logic [31:0] UNIT_VAL  = 32'h0000_0def; // arbitrary value
    logic sys_clk = 1'b0;
    logic sys_rst, hsel, hwrite, hreadyout, hresp, cpu_lockup, lockup_reset;
    logic [31:0] haddr, hwdata, hrdata, adr;
    logic [31:0] fuse_word = FUSE_WORD;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [24:0] blk_rst_n, blk_clk_en, pin_access_en;
    logic rom_cs_n, rom_sck, rom_so, rom_si, load_wr, core_hold;
    logic [16:0] load_addr;
    logic [7:0]  load_data, op;
    int fail_count = 0;
    int comparisons = 0;
    int frames = 0;

    scb_sysctl #(.CPU_ID(CPU_VAL), .UNIT_ID(UNIT_VAL), .WAIT_OSC('{8{20'h00001}})) dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fuse_boot_word(fuse_word),
        .fuse_tag(TAG_VAL), .cpu_lockup(cpu_lockup), .lockup_reset(lockup_reset),
        .blk_rst_n(blk_rst_n), .blk_clk_en(blk_clk_en), .pin_access_en(pin_access_en),
        .rom_cs_n(rom_cs_n), .rom_sck(rom_sck), .rom_so(rom_so), .rom_si(rom_si),
        .load_wr(load_wr), .load_addr(load_addr), .load_data(load_data), .core_hold(core_hold));
    scb_rom_model mem (.rom_cs_n(rom_cs_n), .rom_sck(rom_sck), .rom_so(rom_so),
        .rom_si(rom_si), .op(op), .adr(adr));

    always #10 sys_clk = ~sys_clk;
    always @(negedge rom_cs_n) frames++;
    // ****************
    // helpers
    // ****************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {20'h0, a};
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        logic [31:0] x;
        bus(1'b1, a, wd, x);
    endtask : wr
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(x, exp);
    endtask : rd_chk
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up
    // ****************
    // scenarios
    // ****************
    task automatic t_regs;
        rd_chk(OFF_RST, 32'hffff_ffff);
        rd_chk(OFF_GATE, 32'h0);
        rd_chk(OFF_HANG, 32'h1);
        rd_chk(12'h01c, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        wr(OFF_FUSE, 32'hffff_ffff);
        rd_chk(OFF_FUSE, FUSE_WORD);
        wr(OFF_TAG, 32'h0);
        rd_chk(OFF_TAG, TAG_VAL);
        wr(OFF_CPU, 32'h0);
        rd_chk(OFF_CPU, CPU_VAL);
        rd_chk(OFF_UNIT, UNIT_VAL);
        wr(OFF_RST, 32'h0);
        rd_chk(OFF_RST, 32'hfe0c_fc8c);
        chk({7'h0, blk_rst_n & 25'h1f3_0373}, 32'h0);
        wr(OFF_RST, 32'hffff_ffff);
        rd_chk(OFF_RST, 32'hffff_ffff);
        chk({7'h0, blk_rst_n}, 32'h01ff_ffff);
    endtask : t_regs
    task automatic t_gate;
        int c;
        wr(OFF_GATE, 32'hffff_ffff);
        rd_chk(OFF_GATE, 32'h01e3_0373);
        chk({7'h0, blk_clk_en & 25'h1e3_0373}, 32'h01e3_0373);
        chk({7'h0, pin_access_en}, 32'h01e3_0373);
        wr(OFF_GATE, 32'h01a3_0373);
        rd_chk(OFF_GATE, 32'h01a3_0373);
        chk({7'h0, pin_access_en}, 32'h0);
        wr(OFF_GATE, 32'h0);
        repeat (2) @(posedge sys_clk);
        c = 0;
        repeat (512) begin
            @(posedge sys_clk);
            if (blk_clk_en !== 25'h0) c++;
        end
        chk(32'(c), 32'h2);
    endtask : t_gate
    task automatic t_lockup;
        cpu_lockup <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk({31'h0, lockup_reset}, 32'h1);
        wr(OFF_HANG, 32'h0);
        rd_chk(OFF_HANG, 32'h0);
        chk({31'h0, lockup_reset}, 32'h0);
        cpu_lockup <= 1'b0;
    endtask : t_lockup
    task automatic t_boot(input int per, input int nfr, input logic [7:0] opc);
        int c;
        time t0;
        @(posedge rom_sck);
        t0 = $time;
        @(posedge rom_sck);
        chk(32'((($time - t0) / 20)), 32'(per));
        for (int k = 0; k < 4; k++) begin
            c = 0;
            do begin
                @(posedge sys_clk);
                c++;
            end while (load_wr !== 1'b1 && c < 20000);
            chk({15'h0, load_addr}, 32'(k));
            chk({24'h0, load_data}, 32'(k ^ 'h5a));
        end
        chk(32'(frames), 32'(nfr));
        chk({24'h0, op}, {24'h0, opc});
        chk(adr, 32'h0);
        chk({31'h0, core_hold}, 32'h1);
    endtask : t_boot
    // ****************
    // sequence
    // ****************
    initial begin
        sys_rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        cpu_lockup = 1'b0;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        t_regs;
        t_gate;
        t_lockup;
        t_boot(6, 2, 8'h03);
        sys_rst <= 1'b1;
        fuse_word <= FUSE_FAST;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_boot(2, 3, 8'h0f);
        wrap_up;
    end
    // both boots write their first bytes within about 7000 cycles
    initial begin
        repeat (30000) @(posedge sys_clk);
        fail_count++;
        wrap_up;
    end
endmodule : scb_sysctl_bench
`default_nettype wire
